// file: common/rng_pkg.sv
// Constants shared by the random-number source and its entropy health checker.
// Assumes a single system clock; no software-visible register map exists.
package rng_pkg;

   // -----------------------------------------------------------------------
   // Widths and counts
   // -----------------------------------------------------------------------
   localparam int unsigned DATA_W          = 64;
   localparam int unsigned ID_W            = 32;
   localparam int unsigned REP_LIMIT       = 32;
   localparam int unsigned RESEED_INTERVAL = 16;

   // -----------------------------------------------------------------------
   // Identification query encoding
   // -----------------------------------------------------------------------
   localparam logic [ID_W-1:0] LEAF_BASIC    = 32'h0000_0001;
   localparam logic [ID_W-1:0] LEAF_EXT      = 32'h0000_0007;
   localparam logic [ID_W-1:0] SUBLEAF_ZERO  = 32'h0000_0000;
   localparam int unsigned     RAND_FEAT_BIT = 30;
   localparam int unsigned     SEED_FEAT_BIT = 18;
   localparam logic [ID_W-1:0] RAND_FEAT     = 32'h4000_0000;
   localparam logic [ID_W-1:0] SEED_FEAT     = 32'h0004_0000;

   // -----------------------------------------------------------------------
   // Deterministic generator mixing
   // -----------------------------------------------------------------------
   localparam logic [DATA_W-1:0] GEN_INIT  = 64'h6a09_e667_f3bc_c908;
   localparam int unsigned       SH_A      = 13;
   localparam int unsigned       SH_B      = 7;
   localparam int unsigned       SH_C      = 17;
   localparam int unsigned       KEY_ROT   = 29;

endpackage

// file: src/entropy_health.sv
// Entropy collector: packs raw noise bits into words and runs a repetition test.
// Assumes the noise bit is synchronous to clk_sys_i and fresh on every enabled cycle.
`timescale 1ns/1ps
module entropy_health #(
   parameter int unsigned WORD_W    = rng_pkg::DATA_W,
   parameter int unsigned REP_LIMIT = rng_pkg::REP_LIMIT
) (
   input  wire logic              clk_sys_i,
   input  wire logic              rstn_i,
   input  wire logic              ce_i,
   input  wire logic              entropy_bit_i,
   output logic                   word_valid_o,
   output logic [WORD_W-1:0]      word_o,
   output logic                   word_bad_o
);

   localparam int unsigned CNT_W = $clog2(WORD_W);
   localparam int unsigned RUN_W = $clog2(REP_LIMIT + 1);
   localparam logic [CNT_W-1:0] LAST_BIT = CNT_W'(WORD_W - 1);
   localparam logic [RUN_W-1:0] RUN_MAX  = RUN_W'(REP_LIMIT - 1);

   typedef struct packed {
      logic [WORD_W-1:0] shift;
      logic [CNT_W-1:0]  cnt;
      logic [RUN_W-1:0]  run_len;
      logic              last;
      logic              acc_bad;
      logic              out_valid;
      logic [WORD_W-1:0] out_word;
      logic              out_bad;
   } health_s;

   health_s q;
   health_s d;

   always_comb
   begin
      logic rep_fail;
      rep_fail    = 1'b0;
      d           = q;
      d.out_valid = 1'b0;
      d.shift     = {q.shift[WORD_W-2:0], entropy_bit_i};
      if (entropy_bit_i == q.last)
      begin
         if (q.run_len != RUN_MAX)
            d.run_len = q.run_len + 1'b1;
         else
            rep_fail = 1'b1;
      end
      else
      begin
         d.run_len = '0;
      end
      d.last    = entropy_bit_i;
      d.acc_bad = q.acc_bad | rep_fail;
      if (q.cnt == LAST_BIT)
      begin
         // Whole word done: publish it with its health verdict
         d.cnt       = '0;
         d.out_valid = 1'b1;
         d.out_word  = d.shift;
         d.out_bad   = d.acc_bad;
         d.acc_bad   = 1'b0;
      end
      else
      begin
         d.cnt = q.cnt + 1'b1;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i)
   begin
      if (!rstn_i)
         q <= '0;
      else if (ce_i)
         q <= d;
   end

   assign word_valid_o = q.out_valid;
   assign word_o       = q.out_word;
   assign word_bad_o   = q.out_bad;

   // -----------------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------------
   a_rep_run_flag: assert property (
      @(posedge clk_sys_i) disable iff (!rstn_i)
      ce_i && entropy_bit_i == q.last && q.run_len == RUN_MAX && q.cnt != LAST_BIT |=> q.acc_bad)
      else $error("repetition failure not recorded");

   a_bad_word_out: assert property (
      @(posedge clk_sys_i) disable iff (!rstn_i)
      ce_i && q.acc_bad && q.cnt == LAST_BIT |=> word_valid_o && word_bad_o)
      else $error("flagged word published as good");

endmodule

// file: src/hw_random_number_source.sv
// Random-value and seed-value source behind two instructions plus the
// identification feature bits that advertise them.
// Assumes requests are synchronous, one per enabled cycle, with a noise bit
// arriving on every enabled cycle from the on-chip entropy source.
`timescale 1ns/1ps
module hw_random_number_source #(
   parameter int unsigned DATA_W          = rng_pkg::DATA_W,
   parameter int unsigned RESEED_INTERVAL = rng_pkg::RESEED_INTERVAL
) (
   input  wire logic                      clk_sys_i,
   input  wire logic                      rstn_i,
   input  wire logic                      ce_i,
   input  wire logic                      entropy_bit_i,
   input  wire logic                      req_valid_i,
   input  wire logic                      req_seed_i,
   input  wire logic                      id_req_i,
   input  wire logic [rng_pkg::ID_W-1:0]  leaf_select_i,
   input  wire logic [rng_pkg::ID_W-1:0]  subleaf_select_i,
   output logic                           rsp_valid_o,
   output logic [DATA_W-1:0]              rsp_data_o,
   output logic                           carry_flag_o,
   output logic                           id_valid_o,
   output logic [rng_pkg::ID_W-1:0]       second_result_register_o,
   output logic [rng_pkg::ID_W-1:0]       third_result_register_o,
   output logic                           fault_o
);

   localparam int unsigned LEFT_W = $clog2(RESEED_INTERVAL + 1);
   localparam logic [LEFT_W-1:0] LEFT_FULL = LEFT_W'(RESEED_INTERVAL);

   typedef struct packed {
      logic                     rsp_valid;
      logic [DATA_W-1:0]        rsp_data;
      logic                     carry;
      logic                     id_valid;
      logic [rng_pkg::ID_W-1:0] id_second;
      logic [rng_pkg::ID_W-1:0] id_third;
      logic [DATA_W-1:0]        seed_word;
      logic                     seed_full;
      logic                     seed_bad;
      logic [DATA_W-1:0]        gen_state;
      logic [DATA_W-1:0]        gen_key;
      logic [DATA_W-1:0]        gen_last;
      logic [LEFT_W-1:0]        gen_left;
      logic                     gen_bad;
      logic                     fault;
   } src_s;

   src_s q;
   src_s d;

   logic              col_valid;
   logic [DATA_W-1:0] col_word;
   logic              col_bad;

   // -----------------------------------------------------------------------
   // Non-deterministic source with health test
   // -----------------------------------------------------------------------
   entropy_health #(
      .WORD_W    (DATA_W),
      .REP_LIMIT (rng_pkg::REP_LIMIT)
   ) u_health (
      .clk_sys_i     (clk_sys_i),
      .rstn_i        (rstn_i),
      .ce_i          (ce_i),
      .entropy_bit_i (entropy_bit_i),
      .word_valid_o  (col_valid),
      .word_o        (col_word),
      .word_bad_o    (col_bad)
   );

   // -----------------------------------------------------------------------
   // Request handling
   // -----------------------------------------------------------------------
   logic [DATA_W-1:0] gen_next;
   logic [DATA_W-1:0] gen_out;
   logic              gen_ready;

   // Xorshift step whitened by a reseeded key; a compact stand-in for a full
   // block-cipher construction, traded for area in this block
   always_comb
   begin
      logic [DATA_W-1:0] s;
      s          = q.gen_state;
      s          = s ^ (s << rng_pkg::SH_A);
      s          = s ^ (s >> rng_pkg::SH_B);
      s          = s ^ (s << rng_pkg::SH_C);
      gen_next   = s;
      gen_out    = s ^ q.gen_key;
      gen_ready  = (q.gen_left != '0) && !q.gen_bad;
   end

   always_comb
   begin
      d           = q;
      d.rsp_valid = 1'b0;
      d.id_valid  = 1'b0;
      if (req_valid_i)
      begin
         d.rsp_valid = 1'b1;
         d.rsp_data  = '0;
         d.carry     = 1'b0;
         if (req_seed_i)
         begin
            if (q.seed_full)
            begin
               d.seed_full = 1'b0;
               if (!q.seed_bad)
               begin
                  d.rsp_data = q.seed_word;
                  d.carry    = 1'b1;
               end
            end
         end
         else if (gen_ready)
         begin
            if (gen_out == q.gen_last)
            begin
               // Repeated output: poison generator until next good reseed
               d.gen_bad = 1'b1;
            end
            else
            begin
               d.rsp_data  = gen_out;
               d.carry     = 1'b1;
               d.gen_state = gen_next;
               d.gen_left  = q.gen_left - 1'b1;
               d.gen_last  = gen_out;
            end
         end
      end
      // New entropy fills the seed slot first; otherwise a good word reseeds the generator and a bad one poisons it
      if (col_valid)
      begin
         if (!q.seed_full)
         begin
            d.seed_full = 1'b1;
            d.seed_word = col_word;
            d.seed_bad  = col_bad;
         end
         else if (col_bad)
         begin
            d.gen_bad  = 1'b1;
            d.gen_left = '0;
         end
         else
         begin
            d.gen_state = q.gen_state ^ col_word;
            d.gen_key   = q.gen_key ^ {col_word[DATA_W-rng_pkg::KEY_ROT-1:0],
                                       col_word[DATA_W-1:DATA_W-rng_pkg::KEY_ROT]};
            d.gen_left  = LEFT_FULL;
            d.gen_bad   = 1'b0;
         end
      end
      d.fault = d.gen_bad | (d.seed_full & d.seed_bad);
      if (id_req_i)
      begin
         d.id_valid  = 1'b1;
         d.id_second = '0;
         d.id_third  = '0;
         if (leaf_select_i == rng_pkg::LEAF_BASIC)
            d.id_third = rng_pkg::RAND_FEAT;
         else if (leaf_select_i == rng_pkg::LEAF_EXT && subleaf_select_i == rng_pkg::SUBLEAF_ZERO)
            d.id_second = rng_pkg::SEED_FEAT;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         q            <= '0;
         q.gen_state <= rng_pkg::GEN_INIT;
      end
      else if (ce_i)
      begin
         q <= d;
      end
   end

   assign rsp_valid_o              = q.rsp_valid;
   assign rsp_data_o               = q.rsp_data;
   assign carry_flag_o             = q.carry;
   assign id_valid_o               = q.id_valid;
   assign second_result_register_o = q.id_second;
   assign third_result_register_o  = q.id_third;
   assign fault_o                  = q.fault;

   // -----------------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------------
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rstn_i);

   a_rand_id_bit: assert property (
      ce_i && id_req_i && leaf_select_i == rng_pkg::LEAF_BASIC
      |=> id_valid_o && third_result_register_o[rng_pkg::RAND_FEAT_BIT])
      else $error("random feature bit not reported");

   a_seed_id_bit: assert property (
      ce_i && id_req_i && leaf_select_i == rng_pkg::LEAF_EXT && subleaf_select_i == rng_pkg::SUBLEAF_ZERO
      |=> id_valid_o && second_result_register_o[rng_pkg::SEED_FEAT_BIT])
      else $error("seed feature bit not reported");

   a_fail_zero_data: assert property (
      rsp_valid_o && !carry_flag_o |-> rsp_data_o == '0)
      else $error("failed request left data visible");

   a_rand_bad_none: assert property (
      ce_i && req_valid_i && !req_seed_i && q.gen_bad |=> rsp_valid_o && !carry_flag_o)
      else $error("random data delivered while marked bad");

   a_seed_bad_none: assert property (
      ce_i && req_valid_i && req_seed_i && q.seed_full && q.seed_bad |=> rsp_valid_o && !carry_flag_o)
      else $error("seed delivered while marked bad");

   a_rand_underflow: assert property (
      ce_i && req_valid_i && !req_seed_i && q.gen_left == '0 |=> rsp_valid_o && !carry_flag_o)
      else $error("random served while generator empty");

   a_seed_underflow: assert property (
      ce_i && req_valid_i && req_seed_i && !q.seed_full |=> rsp_valid_o && !carry_flag_o)
      else $error("seed served while slot empty");

   a_rand_good_cf: assert property (
      ce_i && req_valid_i && !req_seed_i && gen_ready && gen_out != q.gen_last
      |=> rsp_valid_o && carry_flag_o && rsp_data_o == $past(gen_out))
      else $error("valid random value without carry");

   a_seed_good_cf: assert property (
      ce_i && req_valid_i && req_seed_i && q.seed_full && !q.seed_bad
      |=> rsp_valid_o && carry_flag_o && rsp_data_o == $past(q.seed_word))
      else $error("valid seed without carry");

   a_reseed_load: assert property (
      ce_i && col_valid && !col_bad && q.seed_full |=> q.gen_left == LEFT_FULL && !q.gen_bad)
      else $error("good entropy word did not reseed generator");

endmodule

// file: sim/rng_requester.sv
// Requester model: issues random or seed requests and retries while carry is clear.
// Assumes ce_i stays high while it runs and one answer follows each request.
`timescale 1ns/1ps
module rng_requester #(
   parameter int unsigned LIMIT = 10
) (
   input  wire logic                       clk_sys_i,
   input  wire logic                       rstn_i,
   input  wire logic                       start_i,
   input  wire logic                       seed_i,
   input  wire logic                       rsp_valid_i,
   input  wire logic                       carry_flag_i,
   input  wire logic [rng_pkg::DATA_W-1:0] rsp_data_i,
   output logic                            req_valid_o,
   output logic                            req_seed_o,
   output logic                            done_o,
   output logic                            ok_o,
   output logic [rng_pkg::DATA_W-1:0]      data_o,
   output logic [7:0]                      tries_o
);
   logic busy_q;
   // --------------------------------------------------------------
   // Retry loop; the cap stops a dead generator from hanging us
   // --------------------------------------------------------------
   always @(posedge clk_sys_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         busy_q <= 1'b0;
         req_valid_o <= 1'b0;
         req_seed_o <= 1'b0;
         done_o <= 1'b0;
         ok_o <= 1'b0;
         data_o <= '0;
         tries_o <= 8'h0;
      end
      else
      begin
         req_valid_o <= 1'b0;
         done_o <= 1'b0;
         if (start_i)
         begin
            busy_q <= 1'b1;
            req_valid_o <= 1'b1;
            req_seed_o <= seed_i;
            tries_o <= 8'h1;
         end
         else if (busy_q && rsp_valid_i)
         begin
            if (carry_flag_i || tries_o == 8'(LIMIT))
            begin
               busy_q <= 1'b0;
               done_o <= 1'b1;
               ok_o <= carry_flag_i;
               data_o <= rsp_data_i;
            end
            else
            begin
               req_valid_o <= 1'b1;
               tries_o <= tries_o + 8'h1;
            end
         end
      end
   end
endmodule

// file: sim/testbench.sv
// Self-checking bench for the random-number source.
// Holds ce_i high except during t_hold; the bench owns the noise bit stream.
`timescale 1ns/1ps
`define CHK(a, e) \
   begin \
      comparisons++; \
      if ((a) !== (e)) \
      begin \
         n_fail++; \
         $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); \
      end \
   end
module testbench;
   logic        clk_sys_i, rstn_i, ce_i, entropy_bit_i, tb_req, tb_seed, id_req_i;
   logic [31:0] leaf_select_i, subleaf_select_i, sec_o, thi_o;
   logic        rsp_valid_o, carry_flag_o, id_valid_o, fault_o, m_start, m_seed;
   logic        m_req, m_rseed, m_done, m_ok;
   logic [63:0] rsp_data_o, m_data, d0;
   logic [7:0]  m_tries;
   logic [15:0] ebit;
   int          n_fail, comparisons, cycles;
   wire         req_v = tb_req | m_req;
   wire         req_s = tb_req ? tb_seed : m_rseed;

   hw_random_number_source #(.RESEED_INTERVAL(4)) dut (
      .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .ce_i(ce_i), .entropy_bit_i(entropy_bit_i),
      .req_valid_i(req_v), .req_seed_i(req_s), .id_req_i(id_req_i), .leaf_select_i(leaf_select_i),
      .subleaf_select_i(subleaf_select_i), .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o),
      .carry_flag_o(carry_flag_o), .id_valid_o(id_valid_o), .second_result_register_o(sec_o),
      .third_result_register_o(thi_o), .fault_o(fault_o));

   rng_requester #(.LIMIT(10)) requester (
      .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .start_i(m_start), .seed_i(m_seed),
      .rsp_valid_i(rsp_valid_o), .carry_flag_i(carry_flag_o), .rsp_data_i(rsp_data_o),
      .req_valid_o(m_req), .req_seed_o(m_rseed), .done_o(m_done), .ok_o(m_ok),
      .data_o(m_data), .tries_o(m_tries));

   // --------------------------------------------------------------
   // Noise stream: bits 192..319 stuck low so two words fail health
   // --------------------------------------------------------------
   function automatic logic pat(input logic [15:0] k);
      pat = (k >= 16'h00c0 && k < 16'h0140) ? 1'b0 : k[0] ^ k[2] ^ k[6];
   endfunction

   function automatic logic [63:0] word(input int w);
      for (int i = 0; i < 64; i++)
         word[63-i] = pat(16'(64 * w + i));
   endfunction

   initial
   begin
      clk_sys_i = 1'b0;
      forever #12.5 clk_sys_i = ~clk_sys_i;
   end

   always @(posedge clk_sys_i)
   begin
      if (rstn_i && ce_i)
      begin
         ebit <= ebit + 16'h1;
         entropy_bit_i <= pat(ebit + 16'h1);
      end
   end

   always @(posedge clk_sys_i)
   begin
      cycles <= cycles + 1;
      if (cycles == 2000)
      begin
         n_fail++;
         summarize();
      end
   end

   task summarize;
      if (n_fail == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task wait_to(input logic [15:0] n);
      while (ebit < n)
         @(posedge clk_sys_i);
   endtask

   task req1(input logic s, output logic c, output logic [63:0] d);
      @(posedge clk_sys_i);
      tb_req <= 1'b1;
      tb_seed <= s;
      @(posedge clk_sys_i);
      tb_req <= 1'b0;
      #1;
      `CHK(rsp_valid_o, 1'b1)
      c = carry_flag_o;
      d = rsp_data_o;
   endtask

   task model(input logic s);
      int k;
      @(posedge clk_sys_i);
      m_start <= 1'b1;
      m_seed <= s;
      @(posedge clk_sys_i);
      m_start <= 1'b0;
      k = 0;
      do
      begin
         @(posedge clk_sys_i);
         #1;
         k++;
      end
      while (m_done !== 1'b1 && k < 100);
      `CHK(m_done, 1'b1)
   endtask

   task id1(input logic [31:0] lf, input logic [31:0] sb, input logic [31:0] e3, input logic [31:0] e2);
      @(posedge clk_sys_i);
      id_req_i <= 1'b1;
      leaf_select_i <= lf;
      subleaf_select_i <= sb;
      @(posedge clk_sys_i);
      id_req_i <= 1'b0;
      #1;
      `CHK({id_valid_o, thi_o, sec_o}, {1'b1, e3, e2})
   endtask

   // --------------------------------------------------------------
   // Scenarios
   // --------------------------------------------------------------
   task t_early;
      logic c;
      logic [63:0] d;
      req1(1'b0, c, d);
      `CHK({c, d}, {1'b0, 64'h0})
      req1(1'b1, c, d);
      `CHK({c, d}, {1'b0, 64'h0})
   endtask

   task t_ident;
      id1(32'h1, 32'h0, 32'h4000_0000, 32'h0);
      id1(32'h7, 32'h0, 32'h0, 32'h0004_0000);
      id1(32'h7, 32'h1, 32'h0, 32'h0);
      id1(32'h0, 32'h0, 32'h0, 32'h0);
   endtask

   task t_seed;
      logic c;
      logic [63:0] d;
      req1(1'b1, c, d);
      `CHK({c, d}, {1'b1, word(0)})
      req1(1'b1, c, d);
      `CHK({c, d}, {1'b0, 64'h0})
   endtask

   task t_draws;
      logic c;
      logic [63:0] d;
      model(1'b0);
      `CHK({m_ok, m_tries}, {1'b1, 8'h1})
      d0 = m_data;
      @(posedge clk_sys_i);
      tb_req <= 1'b1;
      tb_seed <= 1'b0;
      // Back to back: the fifth draw since the reseed must run dry
      for (int i = 0; i < 4; i++)
      begin
         @(posedge clk_sys_i);
         if (i == 3)
            tb_req <= 1'b0;
         #1;
         `CHK({rsp_valid_o, carry_flag_o}, {1'b1, i < 3})
         if (i < 3)
            `CHK(rsp_data_o != d0, 1'b1)
         d0 = rsp_data_o;
      end
      `CHK(rsp_data_o, 64'h0)
      model(1'b0);
      `CHK({m_ok, m_tries, m_data}, {1'b0, 8'h0a, 64'h0})
      req1(1'b1, c, d);
      `CHK({c, d}, {1'b1, word(1)})
   endtask

   task t_bad;
      logic c;
      logic [63:0] d;
      `CHK(fault_o, 1'b1)
      req1(1'b0, c, d);
      `CHK({c, d}, {1'b0, 64'h0})
      req1(1'b1, c, d);
      `CHK({c, d}, {1'b0, 64'h0})
   endtask

   task t_recover;
      logic c;
      logic [63:0] d;
      `CHK(fault_o, 1'b0)
      model(1'b0);
      `CHK(m_ok, 1'b1)
      req1(1'b1, c, d);
      `CHK({c, d}, {1'b1, word(5)})
   endtask

   // Query held while ce_i is low must only be answered once enabled
   task t_hold;
      @(posedge clk_sys_i);
      ce_i <= 1'b0;
      id_req_i <= 1'b1;
      leaf_select_i <= 32'h1;
      subleaf_select_i <= 32'h0;
      repeat (3) @(posedge clk_sys_i);
      #1;
      `CHK(id_valid_o, 1'b0)
      @(posedge clk_sys_i);
      ce_i <= 1'b1;
      @(posedge clk_sys_i);
      id_req_i <= 1'b0;
      #1;
      `CHK({id_valid_o, thi_o}, {1'b1, 32'h4000_0000})
   endtask

   initial
   begin
      n_fail = 0;
      comparisons = 0;
      cycles = 0;
      ebit = 16'h0;
      rstn_i = 1'b0;
      ce_i = 1'b1;
      entropy_bit_i = pat(16'h0);
      tb_req = 1'b0;
      tb_seed = 1'b0;
      id_req_i = 1'b0;
      leaf_select_i = 32'h0;
      subleaf_select_i = 32'h0;
      m_start = 1'b0;
      m_seed = 1'b0;
      repeat (5) @(posedge clk_sys_i);
      rstn_i <= 1'b1;
      t_early();
      t_ident();
      wait_to(16'd96);
      t_seed();
      wait_to(16'd200);
      t_draws();
      wait_to(16'd340);
      t_bad();
      wait_to(16'd460);
      t_recover();
      t_hold();
      summarize();
   end
endmodule
